// ### rtl/charger_cfg_pkg.sv
// Shared constants for the charger timer, recharge and boost configuration bank.
package charger_cfg_pkg;

   // Register byte offsets on the serial control port.
   localparam logic [7:0] ADDR_RECHARGE  = 8'h0A;
   localparam logic [7:0] ADDR_OTG_V_HI  = 8'h0B;
   localparam logic [7:0] ADDR_OTG_V_LO  = 8'h0C;
   localparam logic [7:0] ADDR_OTG_I     = 8'h0D;
   localparam logic [7:0] ADDR_TIMER     = 8'h0E;
   localparam logic [7:0] ADDR_CTRL0     = 8'h0F;
   localparam logic [7:0] READ_UNMAPPED  = 8'h00;

   // Reset values; the recharge value excludes the two cell-count bits.
   localparam logic [5:0]  RECHARGE_LOW_RESET = 6'h23;
   localparam logic [10:0] OTG_V_RESET        = 11'h0DC;
   localparam logic [7:0]  OTG_I_RESET        = 8'h4B;
   localparam logic [7:0]  TIMER_RESET        = 8'h3D;
   localparam logic [7:0]  CTRL0_RESET        = 8'hA2;
   // Control-0 bits that the host watchdog returns to default.
   localparam logic [7:0]  CTRL0_WD_MASK      = 8'h2B;
   localparam logic [7:0]  CTRL0_WRITE_MASK   = 8'hFE;

   // Field positions.
   localparam int CELL_MSB = 7;
   localparam int CELL_LSB = 6;
   localparam int OTG_V_HI_BITS = 3;
   localparam int PRECHG_LEN_BIT = 7;

   // Set-point scaling and clamps.
   localparam int             VOTG_BASE_MV   = 2800;
   localparam int             VOTG_STEP_MV   = 10;
   localparam logic [10:0]    VOTG_MAX_CODE  = 11'h780;
   localparam int             IOTG_STEP_MA   = 40;
   localparam logic [6:0]     IOTG_MIN_CODE  = 7'h04;
   localparam int             VRECHG_BASE_MV = 50;
   localparam int             VRECHG_STEP_MV = 50;

   // Filter and timer lengths in their own units.
   localparam int TRECHG_MS_0 = 64;
   localparam int TRECHG_MS_1 = 256;
   localparam int TRECHG_MS_2 = 1024;
   localparam int TRECHG_MS_3 = 2048;
   localparam int PRECHG_LONG_MIN  = 120;
   localparam int PRECHG_SHORT_MIN = 30;
   localparam int TOPOFF_STEP_MIN  = 15;
   localparam int TRICKLE_MIN      = 60;
   localparam int FAST_HRS_0 = 5;
   localparam int FAST_HRS_1 = 8;
   localparam int FAST_HRS_2 = 12;
   localparam int FAST_HRS_3 = 24;

   // Cycles the strap waits after reset so its synchroniser has settled.
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_ADDR     = 3'b001,
      ST_ACK_ADDR = 3'b010,
      ST_PTR      = 3'b011,
      ST_ACK_W    = 3'b100,
      ST_WRITE    = 3'b101,
      ST_READ     = 3'b110,
      ST_RACK     = 3'b111
   } i2c_state_type;

endpackage

// ### rtl/charger_cfg_regs.sv
// Serial-port configuration bank for cell count, recharge, boost and safety timers.
//
// Operation
// - After power-on the cell-count field is loaded from the program-pin strap code.
// - The recharge deglitch selector picks 64, 256, 1024 or 2048 ms and defaults to code 2.
// - The recharge offset is 50 mV plus 50 mV per code and defaults to code 3.
// - The boost voltage is 2800 mV plus 10 mV per code, clamped at 22000 mV, default DCh.
// - The boost current limit is 40 mA per code, clamped low at 160 mA, default 4Bh.
// - The pre-charge timer length bit selects two hours when clear and half an hour when set.
// - The top-off selector disables the timer at code 0 and gives 15, 30 or 45 minutes otherwise.
// - The trickle timer enable switches a fixed one-hour timer and defaults to on.
// - The pre-charge timer enable switches that timer and defaults to on.
// - The fast-charge timer enable switches that timer and defaults to on.
// - The fast-charge length selector picks 5, 8, 12 or 24 hours and defaults to 12.
// - With half speed on, the charge timers run at half rate while limiting or regulating heat.
// - A software register reset restores defaults and restarts the safety timer.
`timescale 1ns/1ps
module charger_cfg_regs
   import charger_cfg_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h55 // Arbitrary target address.
)(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic [1:0]  cell_program_pin,
   input  wire logic        sw_reg_reset,
   input  wire logic        watchdog_expired,
   input  wire logic        input_power_limiting,
   input  wire logic        thermal_regulation,
   output logic             timer_restart,
   output logic      [1:0]  cell_count,
   output logic      [1:0]  recharge_deglitch_sel,
   output logic      [3:0]  recharge_offset,
   output logic      [10:0] boost_voltage_setpoint,
   output logic      [6:0]  boost_current_limit,
   output logic             precharge_timer_len,
   output logic      [1:0]  topoff_timer_sel,
   output logic             trickle_timer_on,
   output logic             precharge_timer_on,
   output logic             fast_timer_on,
   output logic      [1:0]  fast_timer_len,
   output logic             timer_half_speed_on,
   output logic      [7:0]  charger_control_first,
   output logic      [11:0] deglitch_ms,
   output logic      [9:0]  offset_mv,
   output logic      [14:0] boost_mv,
   output logic      [12:0] boost_ma,
   output logic      [7:0]  precharge_min,
   output logic      [5:0]  topoff_min,
   output logic      [5:0]  trickle_min,
   output logic      [4:0]  fast_hours,
   output logic             timer_half_rate
);

   // Synchronisers for the port pins and the strap.
   logic scl_s1_reg, scl_s2_reg, scl_d_reg;
   logic sda_s1_reg, sda_s2_reg, sda_d_reg;
   logic [1:0] strap_s1_reg, strap_s2_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_s1_reg   <= 1'b1;
         scl_s2_reg   <= 1'b1;
         scl_d_reg    <= 1'b1;
         sda_s1_reg   <= 1'b1;
         sda_s2_reg   <= 1'b1;
         sda_d_reg    <= 1'b1;
         strap_s1_reg <= 2'h0;
         strap_s2_reg <= 2'h0;
      end else begin
         scl_s1_reg   <= scl_i;
         scl_s2_reg   <= scl_s1_reg;
         scl_d_reg    <= scl_s2_reg;
         sda_s1_reg   <= sda_i;
         sda_s2_reg   <= sda_s1_reg;
         sda_d_reg    <= sda_s2_reg;
         strap_s1_reg <= cell_program_pin;
         strap_s2_reg <= strap_s1_reg;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise  = scl_s2_reg & ~scl_d_reg;
   assign scl_fall  = ~scl_s2_reg & scl_d_reg;
   assign bus_start = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
   assign bus_stop  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

   // Register storage.
   logic [7:0]  rchg_reg, rchg_next;
   logic [10:0] otg_v_reg, otg_v_next;
   logic [7:0]  otg_i_reg, otg_i_next;
   logic [7:0]  tmr_reg, tmr_next;
   logic [7:0]  ctrl0_reg, ctrl0_next;
   logic [1:0]  strap_wait_reg, strap_wait_next;
   logic        strap_done_reg, strap_done_next;
   logic        restart_reg;

   // Port state.
   i2c_state_type state_reg, state_next;
   logic [2:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] ptr_reg, ptr_next;
   logic       rw_reg, rw_next;
   logic       got_bit_reg, got_bit_next;
   logic       oe_reg, oe_next;
   logic       wr_reg, wr_next;
   logic [7:0] wr_addr_reg, wr_addr_next;
   logic [7:0] wr_data_reg, wr_data_next;

   function automatic logic [7:0] read_byte(input logic [7:0] addr);
      unique case (addr)
         ADDR_RECHARGE: read_byte = rchg_reg;
         ADDR_OTG_V_HI: read_byte = {5'h00, otg_v_reg[10:8]};
         ADDR_OTG_V_LO: read_byte = otg_v_reg[7:0];
         ADDR_OTG_I:    read_byte = otg_i_reg;
         ADDR_TIMER:    read_byte = tmr_reg;
         ADDR_CTRL0:    read_byte = ctrl0_reg;
         default:       read_byte = READ_UNMAPPED;
      endcase
   endfunction

   always_comb begin
      logic [7:0] tx;
      tx           = read_byte(ptr_reg);
      state_next   = state_reg;
      cnt_next     = cnt_reg;
      shift_next   = shift_reg;
      ptr_next     = ptr_reg;
      rw_next      = rw_reg;
      got_bit_next = got_bit_reg;
      oe_next      = oe_reg;
      wr_next      = 1'b0;
      wr_addr_next = wr_addr_reg;
      wr_data_next = wr_data_reg;
      if (bus_start) begin
         state_next   = ST_ADDR;
         cnt_next     = 3'h0;
         oe_next      = 1'b0;
         got_bit_next = 1'b0;
      end else if (bus_stop) begin
         state_next = ST_IDLE;
         oe_next    = 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: ;
            ST_ADDR, ST_PTR, ST_WRITE: begin
               if (scl_rise) begin
                  shift_next   = {shift_reg[6:0], sda_s2_reg};
                  cnt_next     = cnt_reg + 3'h1;
                  got_bit_next = 1'b1;
               end else if (scl_fall && got_bit_reg && cnt_reg == 3'h0
                            && state_reg == ST_ADDR) begin
                  // Eight bits are in once the counter has wrapped. The fall that closes
                  // a start comes before any bit, so a byte only counts after a bit.
                  if (shift_reg[7:1] == DEV_ADDR) begin
                     rw_next    = shift_reg[0];
                     oe_next    = 1'b1;
                     state_next = ST_ACK_ADDR;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end else if (scl_fall && got_bit_reg && cnt_reg == 3'h0) begin
                  if (state_reg == ST_PTR) begin
                     ptr_next = shift_reg;
                  end else begin
                     wr_next      = 1'b1;
                     wr_addr_next = ptr_reg;
                     wr_data_next = shift_reg;
                     ptr_next     = ptr_reg + 8'h01;
                  end
                  oe_next    = 1'b1;
                  state_next = ST_ACK_W;
               end
            end
            ST_ACK_W: begin
               if (scl_fall) begin
                  oe_next    = 1'b0;
                  state_next = ST_WRITE;
               end
            end
            ST_ACK_ADDR, ST_RACK: begin
               if (scl_rise && state_reg == ST_RACK) begin
                  rw_next = ~sda_s2_reg;
               end else if (scl_fall && !rw_reg) begin
                  oe_next    = 1'b0;
                  state_next = (state_reg == ST_RACK) ? ST_IDLE : ST_PTR;
               end else if (scl_fall) begin
                  shift_next = tx;
                  ptr_next   = ptr_reg + 8'h01;
                  oe_next    = ~tx[7];
                  cnt_next   = 3'h0;
                  state_next = ST_READ;
               end
            end
            ST_READ: begin
               if (scl_fall) begin
                  shift_next = {shift_reg[6:0], 1'b0};
                  cnt_next   = cnt_reg + 3'h1;
                  oe_next    = (cnt_reg == 3'h7) ? 1'b0 : ~shift_reg[6];
                  if (cnt_reg == 3'h7) begin
                     state_next = ST_RACK;
                  end
               end
            end
         endcase
      end
   end

   always_comb begin
      logic [10:0] v_new;
      logic        any_reset;
      v_new           = otg_v_reg;
      any_reset       = sw_reg_reset | watchdog_expired;
      rchg_next       = rchg_reg;
      otg_v_next      = otg_v_reg;
      otg_i_next      = otg_i_reg;
      tmr_next        = tmr_reg;
      ctrl0_next      = ctrl0_reg;
      strap_wait_next = strap_wait_reg;
      strap_done_next = strap_done_reg;
      if (any_reset) begin
         // Writes landing in a reset cycle are dropped so defaults are certain.
         rchg_next  = {rchg_reg[CELL_MSB:CELL_LSB], RECHARGE_LOW_RESET};
         otg_v_next = OTG_V_RESET;
         otg_i_next = OTG_I_RESET;
         tmr_next   = TIMER_RESET;
         ctrl0_next = sw_reg_reset ? CTRL0_RESET :
                      (ctrl0_reg & ~CTRL0_WD_MASK) | (CTRL0_RESET & CTRL0_WD_MASK);
      end else if (wr_reg) begin
         unique case (wr_addr_reg)
            ADDR_RECHARGE: rchg_next = wr_data_reg;
            ADDR_OTG_V_HI: v_new = {wr_data_reg[OTG_V_HI_BITS-1:0], otg_v_reg[7:0]};
            ADDR_OTG_V_LO: v_new = {otg_v_reg[10:8], wr_data_reg};
            ADDR_OTG_I: otg_i_next = {wr_data_reg[PRECHG_LEN_BIT],
                           (wr_data_reg[6:0] < IOTG_MIN_CODE) ? IOTG_MIN_CODE
                                                              : wr_data_reg[6:0]};
            ADDR_TIMER:    tmr_next = wr_data_reg;
            ADDR_CTRL0:    ctrl0_next = wr_data_reg & CTRL0_WRITE_MASK;
            default: ;
         endcase
         otg_v_next = (v_new > VOTG_MAX_CODE) ? VOTG_MAX_CODE : v_new;
      end
      if (!strap_done_reg) begin
         strap_wait_next = strap_wait_reg + 2'h1;
         if (strap_wait_reg == STRAP_WAIT) begin
            rchg_next[CELL_MSB:CELL_LSB] = strap_s2_reg;
            strap_done_next              = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= ST_IDLE;
         cnt_reg        <= 3'h0;
         shift_reg      <= 8'h00;
         ptr_reg        <= 8'h00;
         rw_reg         <= 1'b0;
         got_bit_reg    <= 1'b0;
         oe_reg         <= 1'b0;
         wr_reg         <= 1'b0;
         wr_addr_reg    <= 8'h00;
         wr_data_reg    <= 8'h00;
         rchg_reg       <= {2'h0, RECHARGE_LOW_RESET};
         otg_v_reg      <= OTG_V_RESET;
         otg_i_reg      <= OTG_I_RESET;
         tmr_reg        <= TIMER_RESET;
         ctrl0_reg      <= CTRL0_RESET;
         strap_wait_reg <= 2'h0;
         strap_done_reg <= 1'b0;
         restart_reg    <= 1'b0;
      end else begin
         state_reg      <= state_next;
         cnt_reg        <= cnt_next;
         shift_reg      <= shift_next;
         ptr_reg        <= ptr_next;
         rw_reg         <= rw_next;
         got_bit_reg    <= got_bit_next;
         oe_reg         <= oe_next;
         wr_reg         <= wr_next;
         wr_addr_reg    <= wr_addr_next;
         wr_data_reg    <= wr_data_next;
         rchg_reg       <= rchg_next;
         otg_v_reg      <= otg_v_next;
         otg_i_reg      <= otg_i_next;
         tmr_reg        <= tmr_next;
         ctrl0_reg      <= ctrl0_next;
         strap_wait_reg <= strap_wait_next;
         strap_done_reg <= strap_done_next;
         restart_reg    <= sw_reg_reset;
      end
   end

   assign sda_o                  = 1'b0;
   assign sda_oe                 = oe_reg;
   assign timer_restart          = restart_reg;
   assign cell_count             = rchg_reg[CELL_MSB:CELL_LSB];
   assign recharge_deglitch_sel  = rchg_reg[5:4];
   assign recharge_offset        = rchg_reg[3:0];
   assign boost_voltage_setpoint = otg_v_reg;
   assign boost_current_limit    = otg_i_reg[6:0];
   assign precharge_timer_len    = otg_i_reg[PRECHG_LEN_BIT];
   assign topoff_timer_sel       = tmr_reg[7:6];
   assign trickle_timer_on       = tmr_reg[5];
   assign precharge_timer_on     = tmr_reg[4];
   assign fast_timer_on          = tmr_reg[3];
   assign fast_timer_len         = tmr_reg[2:1];
   assign timer_half_speed_on    = tmr_reg[0];
   assign charger_control_first  = ctrl0_reg;

   charger_setting_decode u_decode (
      .clk             (clk),
      .rst_n           (rst_n),
      .deglitch_sel    (rchg_reg[5:4]),
      .offset_code     (rchg_reg[3:0]),
      .votg_code       (otg_v_reg),
      .iotg_code       (otg_i_reg[6:0]),
      .timer_ctrl      (tmr_reg),
      .precharge_len   (otg_i_reg[PRECHG_LEN_BIT]),
      .limiting_active (input_power_limiting | thermal_regulation),
      .deglitch_ms     (deglitch_ms),
      .offset_mv       (offset_mv),
      .boost_mv        (boost_mv),
      .boost_ma        (boost_ma),
      .precharge_min   (precharge_min),
      .topoff_min      (topoff_min),
      .trickle_min     (trickle_min),
      .fast_hours      (fast_hours),
      .timer_half_rate (timer_half_rate)
   );

   a_otg_clamp_high: assert property (@(posedge clk) disable iff (!rst_n)
      otg_v_reg <= 11'h780) else $error("boost voltage code above ceiling");
   a_otg_clamp_low: assert property (@(posedge clk) disable iff (!rst_n)
      otg_i_reg[6:0] >= 7'h04) else $error("boost current code below floor");
   a_swreset_defaults: assert property (@(posedge clk) disable iff (!rst_n)
      sw_reg_reset |=> tmr_reg == 8'h3D && otg_v_reg == 11'h0DC && timer_restart)
      else $error("software reset did not restore defaults");
   a_wd_keeps_cell: assert property (@(posedge clk) disable iff (!rst_n)
      (watchdog_expired && strap_done_reg) |=> cell_count == $past(cell_count)
      && rchg_reg[5:0] == 6'h23) else $error("watchdog disturbed cell count");
   a_cell_from_strap: assert property (@(posedge clk) disable iff (!rst_n)
      (!strap_done_reg && strap_wait_reg == 2'h3) |=> cell_count == $past(strap_s2_reg))
      else $error("cell count not taken from strap");
   a_otg_hi_reserved: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == ST_READ && $past(ptr_reg) == 8'h0B && $past(state_reg) != ST_READ)
      |-> shift_reg[7:3] == 5'h00) else $error("reserved boost bits not zero");

endmodule

// ### rtl/charger_setting_decode.sv
// Turns the stored configuration codes into physical timer and set-point values.
`timescale 1ns/1ps
module charger_setting_decode
   import charger_cfg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  deglitch_sel,
   input  wire logic [3:0]  offset_code,
   input  wire logic [10:0] votg_code,
   input  wire logic [6:0]  iotg_code,
   input  wire logic [7:0]  timer_ctrl,
   input  wire logic        precharge_len,
   input  wire logic        limiting_active,
   output logic      [11:0] deglitch_ms,
   output logic      [9:0]  offset_mv,
   output logic      [14:0] boost_mv,
   output logic      [12:0] boost_ma,
   output logic      [7:0]  precharge_min,
   output logic      [5:0]  topoff_min,
   output logic      [5:0]  trickle_min,
   output logic      [4:0]  fast_hours,
   output logic             timer_half_rate
);

   logic [11:0] deglitch_next;
   logic [4:0]  fast_next;

   always_comb begin
      unique case (deglitch_sel)
         2'h0: deglitch_next = 12'(TRECHG_MS_0);
         2'h1: deglitch_next = 12'(TRECHG_MS_1);
         2'h2: deglitch_next = 12'(TRECHG_MS_2);
         2'h3: deglitch_next = 12'(TRECHG_MS_3);
      endcase
      unique case (timer_ctrl[2:1])
         2'h0: fast_next = 5'(FAST_HRS_0);
         2'h1: fast_next = 5'(FAST_HRS_1);
         2'h2: fast_next = 5'(FAST_HRS_2);
         2'h3: fast_next = 5'(FAST_HRS_3);
      endcase
   end

   // A disabled timer reports a length of zero.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         deglitch_ms     <= '0;
         offset_mv       <= '0;
         boost_mv        <= '0;
         boost_ma        <= '0;
         precharge_min   <= '0;
         topoff_min      <= '0;
         trickle_min     <= '0;
         fast_hours      <= '0;
         timer_half_rate <= 1'b0;
      end else begin
         deglitch_ms     <= deglitch_next;
         offset_mv       <= 10'(VRECHG_BASE_MV + VRECHG_STEP_MV * int'(offset_code));
         boost_mv        <= 15'(VOTG_BASE_MV + VOTG_STEP_MV * int'(votg_code));
         boost_ma        <= 13'(IOTG_STEP_MA * int'(iotg_code));
         precharge_min   <= !timer_ctrl[4] ? 8'h00 :
                            8'(precharge_len ? PRECHG_SHORT_MIN : PRECHG_LONG_MIN);
         topoff_min      <= 6'(TOPOFF_STEP_MIN * int'(timer_ctrl[7:6]));
         trickle_min     <= timer_ctrl[5] ? 6'(TRICKLE_MIN) : 6'h00;
         fast_hours      <= timer_ctrl[3] ? fast_next : 5'h00;
         timer_half_rate <= timer_ctrl[0] & limiting_active;
      end
   end

   // The sampled reset gates the antecedent: at the release edge the outputs still hold zero.
   a_deglitch_default: assert property (@(posedge clk) disable iff (!rst_n)
      rst_n && deglitch_sel == 2'h2 |=> deglitch_ms == 12'h400)
      else $error("deglitch not 1024 ms");
   a_offset_scale: assert property (@(posedge clk) disable iff (!rst_n)
      rst_n |=> int'(offset_mv) == 50 + 50 * int'($past(offset_code)))
      else $error("recharge offset scale wrong");
   a_half_rate: assert property (@(posedge clk) disable iff (!rst_n)
      (timer_ctrl[0] && limiting_active) |=> timer_half_rate)
      else $error("timers not slowed");
   a_trickle_len: assert property (@(posedge clk) disable iff (!rst_n)
      rst_n && timer_ctrl[5] |=> trickle_min == 6'h3C) else $error("trickle timer not one hour");

endmodule

// ### verif/charger_cfg_regs_tb.sv
// Self-checking bench for the charger configuration register bank.
`timescale 1ns/1ps
module charger_cfg_regs_tb
   import charger_cfg_pkg::*;
;
   localparam logic [6:0] DEV = 7'h55; // Arbitrary target address.
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        scl_i = 1'b1;
   logic        m_sda = 1'b1;
   logic [1:0]  cell_program_pin = 2'h2;
   logic        sw_reg_reset = 1'b0;
   logic        watchdog_expired = 1'b0;
   logic        input_power_limiting = 1'b0;
   logic        thermal_regulation = 1'b0;
   logic        sda_oe, timer_restart, timer_half_rate;
   logic [1:0]  cell_count;
   logic [11:0] deglitch_ms;
   logic [9:0]  offset_mv;
   logic [14:0] boost_mv;
   logic [12:0] boost_ma;
   logic [7:0]  precharge_min;
   logic [5:0]  topoff_min, trickle_min;
   logic [4:0]  fast_hours;
   logic [7:0]  ctrl_first;
   logic [10:0] votg_code;
   logic [6:0]  iotg_code;
   logic [3:0]  rofs;
   logic [1:0]  rdeg, topo, flen;
   logic        sda_o, plen, tron, pron, fton, hson;
   int          err_count = 0;
   int          n_tests = 0;
   int          dg[4] = '{64, 256, 1024, 2048};
   int          fh[4] = '{5, 8, 12, 24};
   // The pin is open drain: the wire is low when either party pulls it.
   wire         sda_i = m_sda & ~sda_oe;

   always #5 clk = ~clk;

   charger_cfg_regs #(.DEV_ADDR(DEV)) i_charger_cfg_regs (
      .clk(clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
      .cell_program_pin(cell_program_pin), .sw_reg_reset(sw_reg_reset),
      .watchdog_expired(watchdog_expired), .input_power_limiting(input_power_limiting),
      .thermal_regulation(thermal_regulation), .timer_restart(timer_restart),
      .cell_count(cell_count), .recharge_deglitch_sel(rdeg), .recharge_offset(rofs),
      .boost_voltage_setpoint(votg_code), .boost_current_limit(iotg_code),
      .precharge_timer_len(plen), .topoff_timer_sel(topo), .trickle_timer_on(tron),
      .precharge_timer_on(pron), .fast_timer_on(fton), .fast_timer_len(flen),
      .timer_half_speed_on(hson), .charger_control_first(ctrl_first),
      .deglitch_ms(deglitch_ms), .offset_mv(offset_mv), .boost_mv(boost_mv),
      .boost_ma(boost_ma), .precharge_min(precharge_min), .topoff_min(topoff_min),
      .trickle_min(trickle_min), .fast_hours(fast_hours), .timer_half_rate(timer_half_rate));

   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Each serial phase lasts at least five clocks, above the three the synchroniser needs.
   task automatic xbit(input logic b, output logic r);
      m_sda <= b;
      tk(5);
      scl_i <= 1'b1;
      tk(3);
      r = sda_i;
      tk(2);
      scl_i <= 1'b0;
      tk(1);
   endtask
   task automatic start_c();
      m_sda <= 1'b1;
      tk(5);
      scl_i <= 1'b1;
      tk(5);
      m_sda <= 1'b0;
      tk(5);
      scl_i <= 1'b0;
      tk(1);
   endtask
   task automatic stop_c();
      m_sda <= 1'b0;
      tk(5);
      scl_i <= 1'b1;
      tk(5);
      m_sda <= 1'b1;
      tk(5);
   endtask
   // On a read the ninth bit is the master's refusal, which ends the transfer.
   task automatic xbyte(input logic [7:0] d, input logic rd, output logic [7:0] q);
      logic a;
      for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
      xbit(1'b1, a);
      if (!rd) chk({15'h0000, a}, 16'h0000);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      logic [7:0] q;
      start_c();
      xbyte({DEV, 1'b0}, 1'b0, q);
      xbyte(adr, 1'b0, q);
      xbyte(d, 1'b0, q);
      stop_c();
   endtask
   task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp);
      logic [7:0] q;
      start_c();
      xbyte({DEV, 1'b0}, 1'b0, q);
      xbyte(adr, 1'b0, q);
      start_c();
      xbyte({DEV, 1'b1}, 1'b0, q);
      xbyte(8'hFF, 1'b1, q);
      stop_c();
      chk({8'h00, q}, {8'h00, exp});
   endtask
   task automatic pulse(input logic sw);
      if (sw) sw_reg_reset <= 1'b1;
      else watchdog_expired <= 1'b1;
      tk(1);
      sw_reg_reset <= 1'b0;
      watchdog_expired <= 1'b0;
      #1;
      chk({15'h0000, timer_restart}, {15'h0000, sw});
      tk(3);
   endtask
   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #900000;
      err_count++;
      final_report();
   end

   initial begin
      tk(6);
      rst_n <= 1'b1;
      tk(20);
      chk(16'(cell_count), 16'h0002);
      rdchk(ADDR_RECHARGE, 8'hA3);
      rdchk(ADDR_OTG_V_HI, 8'h00);
      rdchk(ADDR_OTG_V_LO, 8'hDC);
      rdchk(ADDR_OTG_I, 8'h4B);
      rdchk(ADDR_TIMER, 8'h3D);
      rdchk(8'h20, 8'h00);
      chk({cell_count, rdeg, rofs, ctrl_first}, 16'hA3A2);
      chk({sda_o, 4'h0, votg_code}, 16'h00DC);
      chk({plen, iotg_code, topo, tron, pron, fton, flen, hson}, 16'h4B3D);
      chk(16'(offset_mv), 16'(50 + 50 * 3));
      chk(16'(boost_mv), 16'(2800 + 10 * 'hDC));
      chk(16'(boost_ma), 16'(40 * 'h4B));
      chk(16'(precharge_min), 16'(120));
      input_power_limiting <= 1'b1;
      tk(3);
      chk(16'(timer_half_rate), 16'h0001);
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_RECHARGE, 8'(64 + 16 * k + 15));
         chk(16'(deglitch_ms), 16'(dg[k]));
         chk(16'(offset_mv), 16'(800));
         chk(16'(cell_count), 16'h0001);
      end
      wr(ADDR_OTG_V_HI, 8'hFF);
      rdchk(ADDR_OTG_V_HI, 8'h07);
      rdchk(ADDR_OTG_V_LO, 8'h80);
      chk(16'(boost_mv), 16'(22000));
      wr(ADDR_OTG_V_LO, 8'h34);
      chk({5'h00, votg_code}, 16'h0734);
      chk(16'(boost_mv), 16'(2800 + 10 * 'h734));
      wr(ADDR_OTG_I, 8'h81);
      rdchk(ADDR_OTG_I, 8'h84);
      chk(16'(boost_ma), 16'(160));
      chk({plen, iotg_code}, 16'h0084);
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_TIMER, 8'(66 * k + 'h38));
         rdchk(ADDR_TIMER, 8'(66 * k + 'h38));
         chk(16'(topoff_min), 16'(15 * k));
         chk(16'(fast_hours), 16'(fh[k]));
         chk(16'(trickle_min), 16'(60));
         chk(16'(precharge_min), 16'(30));
         chk(16'(timer_half_rate), 16'h0000);
         chk({topo, tron, pron, fton, flen, hson}, 16'(66 * k + 'h38));
      end
      input_power_limiting <= 1'b0;
      thermal_regulation <= 1'b1;
      wr(ADDR_TIMER, 8'h01);
      chk({trickle_min, precharge_min, 2'h0}, 16'h0000);
      chk(16'(fast_hours), 16'h0000);
      chk(16'(timer_half_rate), 16'h0001);
      wr(ADDR_CTRL0, 8'h00);
      pulse(1'b1);
      rdchk(ADDR_RECHARGE, 8'h63);
      rdchk(ADDR_OTG_V_LO, 8'hDC);
      rdchk(ADDR_OTG_I, 8'h4B);
      rdchk(ADDR_TIMER, 8'h3D);
      rdchk(ADDR_CTRL0, 8'hA2);
      wr(ADDR_CTRL0, 8'h00);
      wr(ADDR_TIMER, 8'h00);
      pulse(1'b0);
      rdchk(ADDR_CTRL0, 8'h22);
      chk(16'(ctrl_first), 16'h0022);
      rdchk(ADDR_TIMER, 8'h3D);
      rdchk(ADDR_RECHARGE, 8'h63);
      final_report();
   end
endmodule
